// >>> rtl/burst_buffer.sv
// Burst byte buffer with registered read data
module burst_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_b_i,
   // Write port
   input  wire logic                     we_i,
   input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
   input  wire logic [WIDTH-1:0]         wdata_i,
   // Read port
   input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
   output logic      [WIDTH-1:0]         rdata_o
);
   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad
         $error("burst_buffer: DEPTH must be at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];

   // Storage
   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Registered read
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule

// >>> rtl/host_link_pkg.sv
// Shared constants and types of the serial host link controller
package host_link_pkg;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int          BUS_AW      = 4;
   localparam int          BUS_DW      = 16;
   localparam logic [3:0]  OFS_CTRL    = 4'h0;
   localparam logic [3:0]  OFS_XFER    = 4'h1;
   localparam logic [3:0]  OFS_STATUS  = 4'h2;
   localparam logic [3:0]  OFS_PTR     = 4'h3;
   localparam logic [3:0]  OFS_DATA    = 4'h4;
   localparam int          STAT_BUSY   = 0;
   localparam int          STAT_DONE   = 1;
   localparam int          STAT_NACK   = 2;
   localparam logic [4:0]  CTRL_RESET  = 5'h00;
   localparam logic [15:0] XFER_RESET  = 16'h0000;

   // ----------------------------------------------------------------
   // Far device map and link constants
   // ----------------------------------------------------------------
   localparam logic [6:0]  DEV_ADDR_HIGH   = 7'h29;
   localparam logic [6:0]  DEV_ADDR_LOW    = 7'h28;
   localparam logic [6:0]  CH_COMMAND_IN   = 7'h00;
   localparam logic [6:0]  CH_WAKEUP_OUT   = 7'h01;
   localparam logic [6:0]  CH_NONWAKE_OUT  = 7'h02;
   localparam logic [6:0]  CH_STATUS_OUT   = 7'h03;
   localparam int          QUARTER_CYCLES  = 63;
   localparam int          BUF_DEPTH       = 16;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic split;       // Read through STOP and fresh START
      logic addr_sel;    // Level driven on host_data_out in I2C mode
      logic cpol;        // SPI mode 1/1 when set, 0/0 when clear
      logic three_wire;  // SPI data both ways on host_data
      logic spi;         // SPI protocol when set
   } ctrl_s;

   typedef struct packed {
      logic [7:0] len;   // Data bytes in the burst
      logic       read;  // Read burst when set
      logic [6:0] addr;  // Device register address
   } xfer_s;

   typedef enum logic [2:0] {SEG_DEVW, SEG_REG, SEG_WDATA, SEG_DEVR, SEG_RDATA} seg_e;
   typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_START, ST_BYTE, ST_STOP, ST_DESEL} state_e;

endpackage

// >>> rtl/host_serial_master.sv
// Host side controller of the dual-mode I2C / SPI serial slave port
module host_serial_master
   import host_link_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYCLES,
   parameter int DEPTH   = BUF_DEPTH
) (
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rst_b_i,
   // Register port
   input  wire logic [BUS_AW-1:0] reg_addr_i,
   input  wire logic [BUS_DW-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [BUS_DW-1:0] reg_rdata_o,
   // Serial clock pin
   output logic                   host_clock_o,
   output logic                   host_clock_oe_o,
   // Serial data pin
   input  wire logic              host_data_i,
   output logic                   host_data_o,
   output logic                   host_data_oe_o,
   // Data out / address select pin
   input  wire logic              host_data_out_i,
   output logic                   host_data_out_o,
   output logic                   host_data_out_oe_o,
   // Select pin
   output logic                   host_select_b_o
);
   localparam int         IW      = $clog2(DEPTH);
   localparam logic [7:0] DEPTH_B = 8'(DEPTH);

   generate
      if (DEPTH < 2 || DEPTH > 255) begin : g_bad
         $error("host_serial_master: DEPTH must lie in 2..255");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ctrl_s         ctrl;
   xfer_s         xfer;
   state_e        state;
   seg_e          seg;
   logic          busy;
   logic          done;
   logic          nack;
   logic          start;
   logic          fin_pulse;
   logic          nack_pulse;
   logic          tick;
   logic [1:0]    phase;
   logic [3:0]    bitn;
   logic [7:0]    tx;
   logic [7:0]    rx;
   logic [7:0]    cnt;
   logic [7:0]    cnt_inc;
   logic          scl;
   logic          sda_low;
   logic          mosi;
   logic          sdo_rel;
   logic          cs_b;
   logic          restart_pend;
   logic          eng_we;
   logic [IW-1:0] eng_wa;
   logic [7:0]    eng_wd;
   logic [IW-1:0] ptr;
   logic [IW-1:0] next_ptr;
   logic [7:0]    mem_q;
   logic          sw_data_wr;
   logic          sw_data_rd;
   logic [1:0]    sda_sync;
   logic [1:0]    hdo_sync;
   logic          bit_in;
   logic [6:0]    dev_addr;
   logic          last_rd;

   // ----------------------------------------------------------------
   // Pin synchronisers and derived terms
   // ----------------------------------------------------------------
   // Two flops on each pin read back from the device
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sda_sync <= 2'h3;
         hdo_sync <= 2'h3;
      end else begin
         sda_sync <= {sda_sync[0], host_data_i};
         hdo_sync <= {hdo_sync[0], host_data_out_i};
      end
   end

   assign bit_in     = (ctrl.spi && !ctrl.three_wire) ? hdo_sync[1] : sda_sync[1];
   assign dev_addr   = ctrl.addr_sel ? DEV_ADDR_HIGH : DEV_ADDR_LOW;
   assign cnt_inc    = cnt + 8'h01;
   assign last_rd    = (cnt_inc == xfer.len);
   assign sw_data_wr = reg_wr_i && (reg_addr_i == OFS_DATA) && !busy;
   assign sw_data_rd = reg_rd_i && (reg_addr_i == OFS_DATA) && !busy;
   assign start      = reg_wr_i && (reg_addr_i == OFS_XFER) && !busy
                       && (reg_wdata_i[15:8] <= DEPTH_B)
                       && !(reg_wdata_i[7] && reg_wdata_i[15:8] == 8'h00);

   // Buffer pointer for the next software access
   always_comb begin
      next_ptr = ptr;
      if (reg_wr_i && reg_addr_i == OFS_PTR && !busy) begin
         next_ptr = reg_wdata_i[IW-1:0];
      end else if (sw_data_wr || sw_data_rd) begin
         next_ptr = ptr + IW'(1);
      end
   end

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   tick_divider #(.DIV(QUARTER)) u_div (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .en_i       (busy),
      .tick_o     (tick)
   );

   burst_buffer #(.WIDTH(8), .DEPTH(DEPTH)) u_buf (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .we_i       (busy ? eng_we : sw_data_wr),
      .waddr_i    (busy ? eng_wa : ptr),
      .wdata_i    (busy ? eng_wd : reg_wdata_i[7:0]),
      .raddr_i    (busy ? cnt[IW-1:0] : next_ptr),
      .rdata_o    (mem_q)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Configuration and transfer request, frozen while busy
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= ctrl_s'(CTRL_RESET);
         xfer <= xfer_s'(XFER_RESET);
      end else begin
         if (reg_wr_i && reg_addr_i == OFS_CTRL && !busy) begin
            ctrl <= ctrl_s'(reg_wdata_i[4:0]);
         end
         if (start) begin
            xfer <= xfer_s'(reg_wdata_i);
         end
      end
   end

   // Status flags and buffer pointer
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
         ptr  <= '0;
      end else begin
         ptr <= next_ptr;
         if (start) begin
            busy <= 1'b1;
            done <= 1'b0;
            nack <= 1'b0;
         end else begin
            if (fin_pulse) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            if (nack_pulse) begin
               nack <= 1'b1;
            end
         end
      end
   end

   // Read data in the cycle after the strobe
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_CTRL:   reg_rdata_o <= {11'h000, ctrl};
            OFS_XFER:   reg_rdata_o <= xfer;
            OFS_STATUS: reg_rdata_o <= {13'h0000, nack, done, busy};
            OFS_PTR:    reg_rdata_o <= BUS_DW'(ptr);
            OFS_DATA:   reg_rdata_o <= {8'h00, mem_q};
            default:    reg_rdata_o <= '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Link sequencer
   // ----------------------------------------------------------------
   // Quarter-bit phases: 0 clock low, 1 data, 2 clock high, 3 sample
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state        <= ST_IDLE;
         seg          <= SEG_DEVW;
         phase        <= 2'h0;
         bitn         <= 4'h0;
         tx           <= 8'hff;
         rx           <= 8'h00;
         cnt          <= 8'h00;
         scl          <= 1'b1;
         sda_low      <= 1'b0;
         mosi         <= 1'b1;
         sdo_rel      <= 1'b0;
         cs_b         <= 1'b1;
         restart_pend <= 1'b0;
         fin_pulse    <= 1'b0;
         nack_pulse   <= 1'b0;
         eng_we       <= 1'b0;
         eng_wa       <= '0;
         eng_wd       <= 8'h00;
      end else begin
         fin_pulse  <= 1'b0;
         nack_pulse <= 1'b0;
         eng_we     <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               scl     <= ctrl.spi ? ctrl.cpol : 1'b1;
               sda_low <= 1'b0;
               cs_b    <= 1'b1;
               phase   <= 2'h0;
               bitn    <= 4'h0;
               cnt     <= 8'h00;
               if (start) begin
                  state <= ctrl.spi ? ST_SEL : ST_START;
                  seg   <= ctrl.spi ? SEG_REG : SEG_DEVW;
               end
            end
            ST_SEL: if (tick) begin
               phase <= phase + 2'h1;
               if (phase == 2'h0) scl <= ctrl.cpol;
               if (phase == 2'h1) cs_b <= 1'b0;
               if (phase == 2'h3) state <= ST_BYTE;
            end
            ST_START: if (tick) begin
               phase <= phase + 2'h1;
               if (phase == 2'h0) scl <= 1'b0; // Clock low first: a repeated START follows an ACK
               if (phase == 2'h1) sda_low <= 1'b0;
               if (phase == 2'h2) scl <= 1'b1;
               if (phase == 2'h3) begin
                  sda_low <= 1'b1;
                  state   <= ST_BYTE;
               end
            end
            ST_BYTE: if (tick) begin
               phase <= phase + 2'h1;
               unique case (phase)
                  2'h0: begin
                     scl <= 1'b0;
                     if (bitn == 4'h0) begin
                        unique case (seg)
                           SEG_DEVW:  tx <= {dev_addr, 1'b0};
                           SEG_REG:   tx <= {ctrl.spi & xfer.read, xfer.addr};
                           SEG_WDATA: tx <= mem_q;
                           SEG_DEVR:  tx <= {dev_addr, 1'b1};
                           SEG_RDATA: tx <= 8'hff;
                        endcase
                     end
                  end
                  2'h1: begin
                     if (bitn < 4'h8) begin
                        sda_low <= (seg != SEG_RDATA) && !tx[7];
                        mosi    <= tx[7];
                        sdo_rel <= ctrl.three_wire && seg == SEG_RDATA;
                     end else begin
                        sda_low <= (seg == SEG_RDATA) && !last_rd;
                     end
                  end
                  2'h2: scl <= 1'b1;
                  2'h3: begin
                     if (bitn < 4'h8) begin
                        rx <= {rx[6:0], bit_in};
                        tx <= {tx[6:0], 1'b1};
                     end
                     bitn <= bitn + 4'h1;
                     if ((ctrl.spi && bitn == 4'h7) || bitn == 4'h8) begin
                        bitn <= 4'h0;
                        if (!ctrl.spi && seg != SEG_RDATA && bit_in) begin
                           nack_pulse <= 1'b1;
                           state      <= ST_STOP;
                        end else begin
                           unique case (seg)
                              SEG_DEVW: seg <= SEG_REG;
                              SEG_REG: begin
                                 if (!xfer.read) begin
                                    seg <= SEG_WDATA;
                                    if (xfer.len == 8'h00) begin
                                       state <= ctrl.spi ? ST_DESEL : ST_STOP;
                                    end
                                 end else if (ctrl.spi) begin
                                    seg <= SEG_RDATA;
                                 end else begin
                                    seg          <= SEG_DEVR;
                                    restart_pend <= ctrl.split;
                                    state        <= ctrl.split ? ST_STOP : ST_START;
                                 end
                              end
                              SEG_WDATA: begin
                                 cnt <= cnt_inc;
                                 if (last_rd) state <= ctrl.spi ? ST_DESEL : ST_STOP;
                              end
                              SEG_DEVR: seg <= SEG_RDATA;
                              SEG_RDATA: begin
                                 eng_we <= 1'b1;
                                 eng_wa <= cnt[IW-1:0];
                                 eng_wd <= ctrl.spi ? {rx[6:0], bit_in} : rx;
                                 cnt    <= cnt_inc;
                                 if (last_rd) state <= ctrl.spi ? ST_DESEL : ST_STOP;
                              end
                           endcase
                        end
                     end
                  end
               endcase
            end
            ST_STOP: if (tick) begin
               phase <= phase + 2'h1;
               if (phase == 2'h0) scl <= 1'b0;
               if (phase == 2'h1) sda_low <= 1'b1;
               if (phase == 2'h2) scl <= 1'b1;
               if (phase == 2'h3) begin
                  sda_low <= 1'b0;
                  if (restart_pend) begin
                     restart_pend <= 1'b0;
                     state        <= ST_START;
                  end else begin
                     fin_pulse <= 1'b1;
                     state     <= ST_IDLE;
                  end
               end
            end
            ST_DESEL: if (tick) begin
               phase <= phase + 2'h1;
               if (phase == 2'h0) scl <= ctrl.cpol;
               if (phase == 2'h1) begin
                  cs_b    <= 1'b1;
                  sdo_rel <= 1'b0;
               end
               if (phase == 2'h3) begin
                  fin_pulse <= 1'b1;
                  state     <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // I2C lines are open drain; SPI lines are push-pull
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         host_clock_o       <= 1'b0;
         host_clock_oe_o    <= 1'b0;
         host_data_o        <= 1'b0;
         host_data_oe_o     <= 1'b0;
         host_data_out_o    <= 1'b0;
         host_data_out_oe_o <= 1'b0;
         host_select_b_o    <= 1'b1;
      end else begin
         host_clock_o       <= ctrl.spi & scl;
         host_clock_oe_o    <= ctrl.spi | ~scl;
         host_data_o        <= ctrl.spi & mosi;
         host_data_oe_o     <= ctrl.spi ? ~sdo_rel : sda_low;
         host_data_out_o    <= ctrl.addr_sel;
         host_data_out_oe_o <= ~ctrl.spi;
         host_select_b_o    <= ctrl.spi ? cs_b : 1'b1;
      end
   end

endmodule

// >>> rtl/tick_divider.sv
// Quarter-bit enable pulse divider
module tick_divider #(
   parameter int DIV = 63
) (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_b_i,
   // Control and pulse
   input  wire logic en_i,
   output logic      tick_o
);
   localparam int CW = $clog2(DIV);

   generate
      if (DIV < 4) begin : g_bad
         $error("tick_divider: DIV must be at least 4");
      end
   endgenerate

   logic [CW-1:0] count;

   // Count while enabled and pulse once per period
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else if (!en_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else if (count == CW'(DIV - 1)) begin
         count  <= '0;
         tick_o <= 1'b1;
      end else begin
         count  <= count + CW'(1);
         tick_o <= 1'b0;
      end
   end
endmodule

// >>> test/host_device_model.sv
// Behavioural I2C slave standing in for the sensor hub; it never drives the clock, only the data pull-down
module host_device_model (
   // Bus lines
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic strap_i,
   input  wire logic sel_b_i,
   // Scenario control and data pull-down
   input  wire logic absent_i,
   output logic      pull_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:127];
   logic [7:0] sh;
   logic [6:0] ptr;
   logic       spi;
   int         bc;
   int         ph;  // 0 idle, 1 device address, 2 register, 3 write data, 4 read data
   // Known contents for read bursts
   initial begin
      pull_o = 1'b0;
      spi = 1'b0;
      ph = 0;
      bc = 0;
      ptr = '0;
      for (int i = 0; i < 128; i++) mem[i] = 8'(i * 3 + 1);
   end
   // Any low select moves the port to SPI for good
   always @(negedge sel_b_i) spi = 1'b1;
   // START and STOP conditions
   always @(negedge sda_i) if (scl_i && !spi) begin
      ph = 0 + 1;
      bc = 0;
      pull_o = 1'b0;
   end
   always @(posedge sda_i) if (scl_i) ph = 0;
   // Bits taken on the rising clock, MSB first; host NACK ends a read
   always @(posedge scl_i) if (ph != 0) begin
      if (bc < 8) sh = {sh[6:0], sda_i};
      else if (ph == 4 && sda_i) ph = 0;
      bc = bc + 1;
   end
   // Acknowledge and read data go out after the falling clock
   always @(negedge scl_i) if (ph != 0) begin
      if (bc == 9) begin
         bc = 0;
         pull_o = 1'b0;
      end
      if (bc == 8) case (ph)
         1: if (!absent_i && sh[7:1] == (strap_i ? 7'h29 : 7'h28)) begin
            pull_o = 1'b1;
            ph = sh[0] ? 4 : 2;
         end else ph = 0;
         2: begin
            ptr = sh[6:0];
            pull_o = 1'b1;
            ph = 3;
         end
         3: begin
            mem[ptr] = sh;
            ptr = ptr + 1;
            pull_o = 1'b1;
         end
         default: begin
            pull_o = 1'b0;
            if (ptr > 7'h03) ptr = ptr + 1;
         end
      endcase
      else if (ph == 4) pull_o = (ptr > 7'h03) ? ~mem[ptr][7 - bc] : 1'b0;
   end
endmodule

// >>> test/host_link_assertions.sv
// Port-level protocol checker for the host serial link controller
module host_link_assertions
   import host_link_pkg::*;
#(
   parameter int QUARTER = 4
) (
   // Clock, reset and register port
   input wire logic              core_clk_i,
   input wire logic              rst_b_i,
   input wire logic [BUS_AW-1:0] reg_addr_i,
   input wire logic              reg_rd_i,
   input wire logic [BUS_DW-1:0] reg_rdata_o,
   // Serial pins
   input wire logic              host_clock_o,
   input wire logic              host_clock_oe_o,
   input wire logic              host_data_o,
   input wire logic              host_data_oe_o,
   input wire logic              host_data_out_oe_o,
   input wire logic              host_select_b_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Pin levels that must hold for the rest of a quarter bit
   sequence oe_still;
      $stable(host_clock_oe_o)[*3];
   endsequence
   sequence clk_still;
      $stable(host_clock_o)[*3];
   endsequence
   chk_unmapped_zero: assert property (
      reg_rd_i && reg_addr_i > OFS_DATA |=> reg_rdata_o == '0) else $error("unmapped read");
   chk_rdata_holds: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
   chk_clock_od: assert property (
      host_data_out_oe_o && host_clock_oe_o |-> !host_clock_o) else $error("scl driven high");
   chk_data_od: assert property (
      host_data_out_oe_o && host_data_oe_o |-> !host_data_o) else $error("sda driven high");
   chk_i2c_no_select: assert property (
      host_data_out_oe_o |-> host_select_b_o) else $error("select low in i2c");
   chk_select_idle_clk: assert property (
      $fell(host_select_b_o) |=> clk_still) else $error("clock moved at select");
   chk_spi_data_edge: assert property (
      !host_select_b_o && $rose(host_clock_o) |-> $stable(host_data_o)) else $error("mosi edge");
   chk_clock_quarter: assert property (
      $changed(host_clock_oe_o) |=> oe_still) else $error("scl quarter short");
endmodule

bind host_serial_master host_link_assertions #(.QUARTER(QUARTER)) host_link_assertions_i (
   .core_clk_i, .rst_b_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .host_clock_o,
   .host_clock_oe_o, .host_data_o, .host_data_oe_o, .host_data_out_oe_o, .host_select_b_o);

// >>> test/tb.sv
// Self-checking bench for the host serial link controller
module tb
   import host_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, dev_pull, dev_absent;
   logic [BUS_AW-1:0] reg_addr_i;
   logic [BUS_DW-1:0] reg_wdata_i, reg_rdata_o;
   logic              host_clock_o, host_clock_oe_o, host_data_o, host_data_oe_o;
   logic              host_data_out_o, host_data_out_oe_o, host_select_b_o;
   logic [15:0]       spi_sh;
   int                n_fail, checks_done;
   wire               scl = host_clock_oe_o ? host_clock_o : 1'b1;
   wire               sda = (host_data_oe_o ? host_data_o : 1'b1) & ~dev_pull;
   wire               hdo = host_data_out_oe_o ? host_data_out_o : 1'b1;
   host_serial_master #(.QUARTER(4)) host_serial_master_i (.core_clk_i, .rst_b_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .host_clock_o,
      .host_clock_oe_o, .host_data_i(sda), .host_data_o, .host_data_oe_o,
      .host_data_out_i(hdo), .host_data_out_o, .host_data_out_oe_o, .host_select_b_o);
   host_device_model host_device_model_i (.scl_i(scl), .sda_i(sda), .strap_i(hdo),
      .sel_b_i(host_select_b_o), .absent_i(dev_absent), .pull_o(dev_pull));
   // Clock and SPI word capture on the rising serial clock
   always #5 core_clk_i = ~core_clk_i;
   always @(posedge scl) if (!host_select_b_o) spi_sh <= {spi_sh[14:0], host_data_o};
   task automatic summarize();
      $display("Checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Register port cycles, one idle cycle after each strobe
   task automatic wr(logic [3:0] a, logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rd(logic [3:0] a, output logic [15:0] d);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      d = reg_rdata_o;
   endtask
   // Start a transfer and wait for busy to drop
   task automatic run(logic [15:0] x, logic [15:0] exp_stat);
      logic [15:0] s;
      int i;
      wr(OFS_XFER, x);
      s = 16'h0001;
      for (i = 0; i < 3000 && s[STAT_BUSY] !== 1'b0; i++) rd(OFS_STATUS, s);
      if (i == 3000) begin
         n_fail++;
         $display("Error link timeout");
         summarize();
      end
      check("status", exp_stat, s);
   endtask
   task automatic wrbuf(logic [23:0] v);
      wr(OFS_PTR, 16'h0000);
      for (int i = 0; i < 3; i++) wr(OFS_DATA, {8'h00, v[23 - 8 * i -: 8]});
   endtask
   task automatic rdbuf(logic [23:0] v, int n);
      logic [15:0] d;
      wr(OFS_PTR, 16'h0000);
      for (int i = 0; i < n; i++) begin
         rd(OFS_DATA, d);
         check("buffer byte", {8'h00, v[23 - 8 * i -: 8]}, d);
      end
   endtask
   task automatic t_reset_values();
      logic [15:0] d;
      rd(OFS_CTRL, d);
      check("ctrl", {11'h000, CTRL_RESET}, d);
      rd(OFS_XFER, d);
      check("xfer", XFER_RESET, d);
      rd(4'hf, d);
      check("unmapped", 16'h0000, d);
   endtask
   task automatic t_i2c_write();
      wr(OFS_CTRL, 16'h0008);
      wrbuf(24'ha53c0f);
      run(16'h0310, 16'h0002);
      check("dev mem", 16'ha53c, {host_device_model_i.mem[16], host_device_model_i.mem[17]});
      check("dev mem", 16'h000f, {8'h00, host_device_model_i.mem[18]});
   endtask
   task automatic t_i2c_reads();
      wr(OFS_CTRL, 16'h0000);
      run(16'h0391, 16'h0002);
      rdbuf(24'h3c0f3a, 3);
      wr(OFS_CTRL, 16'h0018);
      run(16'h0290, 16'h0002);
      rdbuf(24'ha53c00, 2);
      dev_absent <= 1'b1;
      run(16'h0190, 16'h0006);
      dev_absent <= 1'b0;
   endtask
   task automatic t_spi_write();
      wr(OFS_CTRL, 16'h0001);
      wrbuf(24'hc30000);
      run(16'h0105, 16'h0002);
      check("spi word", 16'h05c3, spi_sh);
      check("select", 16'h0001, {15'h0000, host_select_b_o});
   endtask
   initial begin
      core_clk_i = 1'b0;
      rst_b_i = 1'b0;
      {reg_wr_i, reg_rd_i, dev_absent} = 3'h0;
      reg_addr_i = '0;
      reg_wdata_i = '0;
      {n_fail, checks_done} = {32'h0, 32'h0};
      repeat (16) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      @(posedge core_clk_i);
      t_reset_values();
      t_i2c_write();
      t_i2c_reads();
      t_spi_write();
      summarize();
   end
endmodule
